// [rtl/rsc_pkg.sv]
// Contract
// - A divide-by-eight counter with eight one-hot outputs steps once per oscillator pulse.
// - A low hold stops the oscillator; releasing it issues exactly one step pulse.
// - The first state is entered after the last state on a step, or at once on counter reset.
// - Entering the first state sets the output latch and drives switch-on high.
// - Hold and the amplitude counter reset act only while the last state is active; a run edge resets from any state.
// - The latch clears on a negative switch voltage or on the sixth state.
// - The negative-voltage indication is ignored during the first state.
// - A low switch amplitude in the last state resets the counter and turns the switch on.
// - Inductor current below reference releases hold and steps last state to first.
// - A rising run resets the counter, enters the first state and turns the switch on.
// - An activity monitor shows stopped or active; only when active may the amplitude path reset.
// - The current comparator reaches hold release only while run is high.
// - With run low the current comparator starts no new cycle; the counter runs to the last state and holds.
package rsc_pkg;
    localparam int unsigned RSC_STATES = 8;
    localparam logic [7:0] RSC_FIRST = 8'h01;
    localparam logic [7:0] RSC_SIXTH = 8'h20;
    localparam logic [7:0] RSC_LAST = 8'h80;
    localparam int unsigned RSC_DIV_W = 16;
    localparam logic [15:0] RSC_DIV_RESET = 16'h0004;
    localparam int unsigned RSC_ACT_W = 16;
    localparam logic [15:0] RSC_ACT_TIMEOUT = 16'h0100;
    localparam logic [31:0] RSC_ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] RSC_ADDR_DIV = 32'h0000_0004;
    localparam logic [31:0] RSC_ADDR_STAT = 32'h0000_0008;
    localparam int unsigned RSC_CTRL_RUN = 0;
    localparam logic [1:0] RSC_RESP_OKAY = 2'b00;
    localparam logic [1:0] RSC_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic current_below;
        logic voltage_negative;
        logic amplitude_below;
        logic run;
    } rsc_sense_t;
endpackage

// [rtl/rsc_controller.sv]
`timescale 1ns/1ps
module rsc_controller
    import rsc_pkg::*;
#(
    parameter logic [15:0] ACT_TIMEOUT = RSC_ACT_TIMEOUT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // analogue comparators and run pin
    input wire logic current_comparator,
    input wire logic polarity_comparator,
    input wire logic amplitude_comparator,
    input wire logic run_request_input,
    // power stage
    output logic switch_on_output,
    output logic [7:0] count_state,
    output logic activity_monitor,
    // axi4-lite write
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // synchronisers
    rsc_sense_t meta_reg, meta_next, sync_reg, sync_next;
    always_comb begin
        meta_next = '{current_comparator, polarity_comparator, amplitude_comparator,
                      run_request_input};
        sync_next = meta_reg;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    // registers written by software
    logic [15:0] div_reg, div_next;
    logic sw_run_reg, sw_run_next;
    // axi state
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    // cycle state
    logic [7:0] state_reg, state_next;
    logic latch_reg, latch_next;
    logic run_d_reg, run_d_next;
    logic [15:0] div_cnt_reg, div_cnt_next;
    logic [15:0] idle_cnt_reg, idle_cnt_next;
    logic held_reg, held_next;
    logic latch_d_reg, latch_d_next;
    logic active_reg, active_next;

    logic run_eff, run_rise, in_last, tick, step, counter_reset, release_hold;

    always_comb begin
        run_eff = sync_reg.run & sw_run_reg;
        run_rise = run_eff & ~run_d_reg;
        in_last = state_reg[RSC_STATES-1];
        release_hold = sync_reg.current_below & run_eff;
        // counter reset: run edge, or emergency amplitude path while active in last state
        counter_reset = run_rise
            | (in_last & sync_reg.amplitude_below & active_reg);
        tick = (div_cnt_reg == 16'h0000);
        // hold gates the oscillator only in the last state; release gives one step
        step = in_last ? (held_reg & release_hold) : tick;
        div_cnt_next = tick ? div_reg : div_cnt_reg - 16'h0001;
        held_next = in_last ? (held_reg | tick) & ~step : 1'b0;
        run_d_next = run_eff;
        state_next = state_reg;
        if (counter_reset) begin
            state_next = RSC_FIRST;
            div_cnt_next = div_reg;
        end else if (step) begin
            state_next = {state_reg[RSC_STATES-2:0], state_reg[RSC_STATES-1]};
            div_cnt_next = div_reg;
        end
        latch_next = latch_reg;
        if (state_reg[0]) begin
            latch_next = 1'b1;
        end else if ((state_reg & RSC_SIXTH) != 8'h00 || sync_reg.voltage_negative) begin
            latch_next = 1'b0;
        end
        // activity: a switch-on edge restarts the timeout
        latch_d_next = latch_reg;
        if (latch_reg & ~latch_d_reg) begin
            idle_cnt_next = ACT_TIMEOUT;
        end else if (idle_cnt_reg != 16'h0000) begin
            idle_cnt_next = idle_cnt_reg - 16'h0001;
        end else begin
            idle_cnt_next = idle_cnt_reg;
        end
        active_next = (idle_cnt_next != 16'h0000);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= RSC_LAST;
            latch_reg <= 1'b0;
            run_d_reg <= 1'b0;
            div_cnt_reg <= RSC_DIV_RESET;
            held_reg <= 1'b0;
            idle_cnt_reg <= 16'h0000;
            latch_d_reg <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            latch_reg <= latch_next;
            run_d_reg <= run_d_next;
            div_cnt_reg <= div_cnt_next;
            held_reg <= held_next;
            idle_cnt_reg <= idle_cnt_next;
            latch_d_reg <= latch_d_next;
            active_reg <= active_next;
        end
    end

    assign switch_on_output = latch_reg;
    assign count_state = state_reg;
    assign activity_monitor = active_reg;

    // axi4-lite slave; address and data may come in either order
    logic aw_have, w_have, do_write, do_read;
    logic [31:0] wa, wd;
    logic [3:0] ws;
    always_comb begin
        aw_have = aw_hold_reg | s_axi_awvalid;
        w_have = w_hold_reg | s_axi_wvalid;
        do_write = aw_have & w_have & ~bvalid_reg;
        wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
        wd = w_hold_reg ? wdata_reg : s_axi_wdata;
        ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;
        s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
        s_axi_wready = ~w_hold_reg & ~bvalid_reg;
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        div_next = div_reg;
        sw_run_next = sw_run_reg;
        bvalid_next = bvalid_reg & ~s_axi_bready;
        bresp_next = bresp_reg;
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RSC_RESP_OKAY;
            if (wa[7:0] == RSC_ADDR_CTRL[7:0] && wa[31:8] == 24'h0) begin
                if (ws[0]) sw_run_next = wd[RSC_CTRL_RUN];
            end else if (wa[7:0] == RSC_ADDR_DIV[7:0] && wa[31:8] == 24'h0) begin
                if (ws[0]) div_next[7:0] = wd[7:0];
                if (ws[1]) div_next[15:8] = wd[15:8];
            end else begin
                bresp_next = RSC_RESP_SLVERR;
            end
        end
        s_axi_arready = ~rvalid_reg;
        do_read = s_axi_arvalid & ~rvalid_reg;
        rvalid_next = rvalid_reg & ~s_axi_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (do_read) begin
            rvalid_next = 1'b1;
            rresp_next = RSC_RESP_OKAY;
            if (s_axi_araddr == RSC_ADDR_CTRL) rdata_next = {31'h0, sw_run_reg};
            else if (s_axi_araddr == RSC_ADDR_DIV) rdata_next = {16'h0, div_reg};
            else if (s_axi_araddr == RSC_ADDR_STAT)
                rdata_next = {20'h0, active_reg, latch_reg, run_eff, held_reg, state_reg};
            else begin
                rdata_next = 32'h0;
                rresp_next = RSC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= RSC_DIV_RESET;
            sw_run_reg <= 1'b1;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 32'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'b00;
            rdata_reg <= 32'h0;
        end else begin
            div_reg <= div_next;
            sw_run_reg <= sw_run_next;
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // checks
    one_hot_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $onehot(state_reg)) else $error("count state not one-hot");
    first_sets_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg[0] |=> latch_reg) else $error("first state did not set switch");
    sixth_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == RSC_SIXTH) |=> !latch_reg) else $error("sixth state kept switch");
    blank_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(state_reg[0]) |=> latch_reg[*2]) else $error("switch cleared in blank");
    hold_last_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_last && !counter_reset && !(held_reg && release_hold)) |=> in_last)
        else $error("left last state while held");
    run_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run_rise |=> state_reg == RSC_FIRST ##1 latch_reg)
        else $error("run edge did not start cycle");
    gate_current_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!run_eff && in_last && !counter_reset) |=> in_last)
        else $error("cycle started with run low");
    emergency_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_last && sync_reg.amplitude_below && active_reg) |=> state_reg[0])
        else $error("emergency reset missed");
endmodule // rsc_controller

// [verification/rsc_stage_model.sv]
`timescale 1ns/1ps
module rsc_stage_model (
    // clock
    input wire logic aclk,
    // switch command
    input wire logic switch_on,
    // bench knobs
    input wire logic cur_en,
    input wire logic neg_en,
    input wire logic amp_en,
    // comparator outputs
    output logic current_below,
    output logic voltage_negative,
    output logic amplitude_below
);
    logic [1:0] off_cnt_reg = 2'h0;
    // inductor current only decays once the switch has opened
    always_ff @(posedge aclk) begin
        if (switch_on) begin
            off_cnt_reg <= 2'h0;
        end else if (off_cnt_reg != 2'h3) begin
            off_cnt_reg <= off_cnt_reg + 2'h1;
        end
        current_below <= cur_en & (off_cnt_reg == 2'h3);
        voltage_negative <= neg_en;
        amplitude_below <= amp_en;
    end
endmodule // rsc_stage_model

// [verification/resonant_switch_cycle_controller_tb.sv]
`timescale 1ns/1ps
module resonant_switch_cycle_controller_tb
    import rsc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic run = 1'b0;
    logic cur_en = 1'b0;
    logic neg_en = 1'b0;
    logic amp_en = 1'b0;
    logic cur_b, pol_n, amp_b, sw, act;
    logic [7:0] st;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, q;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    int fails = 0;
    int checks = 0;
    initial begin
        forever #20 aclk = ~aclk;
    end
    rsc_stage_model stage (.aclk(aclk), .switch_on(sw), .cur_en(cur_en), .neg_en(neg_en),
        .amp_en(amp_en), .current_below(cur_b), .voltage_negative(pol_n),
        .amplitude_below(amp_b));
    rsc_controller #(.ACT_TIMEOUT(16'h0040)) uut (.aclk(aclk), .aresetn(aresetn),
        .current_comparator(cur_b), .polarity_comparator(pol_n),
        .amplitude_comparator(amp_b), .run_request_input(run), .switch_on_output(sw),
        .count_state(st), .activity_monitor(act), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic give_verdict();
        $display("fails %0d checks %0d", fails, checks);
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bail();
        chk("wait", 32'h0, 32'h1);
        give_verdict();
    endtask
    task automatic axi(input logic we, input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, tr, dn;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= we;
        wvalid <= we;
        bready <= we;
        arvalid <= ~we;
        rready <= ~we;
        repeat (50) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tr = arvalid & arready;
            dn = (bvalid & bready) | (rvalid & rready);
            q = rdata;
            r = we ? bresp : rresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (dn) begin
                bready <= 1'b0;
                rready <= 1'b0;
                return;
            end
        end
        bail();
    endtask
    // waits for a one-hot state, a hang ends the run
    task automatic wst(input logic [7:0] e);
        repeat (200) begin
            @(negedge aclk);
            if (st === e) return;
        end
        bail();
    endtask
    task automatic t_regs();
        axi(1'b0, RSC_ADDR_CTRL, 32'h0);
        chk("ctrl", q, 32'h1);
        axi(1'b0, RSC_ADDR_DIV, 32'h0);
        chk("div", q, {16'h0, RSC_DIV_RESET});
        axi(1'b0, RSC_ADDR_STAT, 32'h0);
        chk("stat", {24'h0, q[7:0]}, {24'h0, RSC_LAST});
        axi(1'b0, 32'h0000_0010, 32'h0);
        chk("rresp", {30'h0, r} | q, {30'h0, RSC_RESP_SLVERR});
        axi(1'b1, 32'h0000_0010, 32'h5);
        chk("bresp", {30'h0, r}, {30'h0, RSC_RESP_SLVERR});
        axi(1'b1, RSC_ADDR_DIV, 32'h1);
        axi(1'b0, RSC_ADDR_DIV, 32'h0);
        chk("div", q, 32'h1);
        // only the upper byte is strobed, so the low byte must keep its value
        wstrb <= 4'h2;
        axi(1'b1, RSC_ADDR_DIV, 32'h5);
        wstrb <= 4'hf;
        axi(1'b0, RSC_ADDR_DIV, 32'h0);
        chk("div strobe", q, 32'h1);
    endtask
    task automatic t_start();
        int i;
        @(posedge aclk);
        run <= 1'b1;
        wst(RSC_FIRST);
        for (i = 1; i < 8; i++) begin
            wst(8'h01 << i);
            chk("switch", {31'h0, sw}, {31'h0, i < 6});
        end
        repeat (20) @(negedge aclk);
        chk("held", {24'h0, st}, {24'h0, RSC_LAST});
        @(posedge aclk);
        cur_en <= 1'b1;
        wst(RSC_FIRST);
    endtask
    task automatic t_blank();
        @(posedge aclk);
        neg_en <= 1'b1;
        wst(RSC_LAST);
        wst(RSC_FIRST);
        @(negedge aclk);
        chk("blanked", {31'h0, sw}, 32'h1);
        wst(8'h02);
        @(negedge aclk);
        chk("neg clear", {31'h0, sw}, 32'h0);
        @(posedge aclk);
        neg_en <= 1'b0;
    endtask
    task automatic t_emerg();
        @(posedge aclk);
        cur_en <= 1'b0;
        wst(RSC_LAST);
        repeat (6) @(negedge aclk);
        chk("held", {24'h0, st}, {24'h0, RSC_LAST});
        chk("active", {31'h0, act}, 32'h1);
        @(posedge aclk);
        amp_en <= 1'b1;
        wst(RSC_FIRST);
        @(negedge aclk);
        chk("emerg on", {31'h0, sw}, 32'h1);
        @(posedge aclk);
        amp_en <= 1'b0;
    endtask
    task automatic t_stop();
        @(posedge aclk);
        run <= 1'b0;
        cur_en <= 1'b1;
        wst(RSC_LAST);
        repeat (20) @(negedge aclk);
        chk("stopped", {24'h0, st}, {24'h0, RSC_LAST});
        repeat (80) @(negedge aclk);
        chk("idle", {31'h0, act}, 32'h0);
        @(posedge aclk);
        amp_en <= 1'b1;
        repeat (10) @(negedge aclk);
        chk("no emerg", {24'h0, st}, {24'h0, RSC_LAST});
        // held, run low, switch off, inactive, last state
        axi(1'b0, RSC_ADDR_STAT, 32'h0);
        chk("stat stop", q, 32'h0000_0180);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_start();
        t_blank();
        t_emerg();
        t_stop();
        give_verdict();
    end
endmodule // resonant_switch_cycle_controller_tb
